/* hw/sts_defs.vh */
// Purpose: constants for the system temperature supervisor
// Assumes: 25 MHz clock
// Notes:   temperatures are signed 8-bit whole degrees C
`ifndef STS_DEFS_VH
`define STS_DEFS_VH

// ********************************************************
// Bus map and register layout
// ********************************************************
`define STS_IO_BASE        10'h250
`define STS_IO_SPAN_BITS   3
`define STS_IDX_SIGNATURE  3'h0
`define STS_IDX_STATUS     3'h1
`define STS_IDX_CONTROL    3'h5
`define STS_SIGNATURE_VAL  8'h5A  // Arbitrary value
`define STS_RANGE_LSB      0
`define STS_MAINS_BIT      2
`define STS_BATT_BIT       3
`define STS_CTRL_RESET     8'h00

// ********************************************************
// Temperature ranges and thresholds
// ********************************************************
`define STS_RANGE_COLD     2'h0
`define STS_RANGE_COOL     2'h1
`define STS_RANGE_WARM     2'h2
`define STS_RANGE_HOT      2'h3
`define STS_T_COLD_LO      8'sh00
`define STS_T_COLD_HI      8'sh03
`define STS_T_WARM_LO      8'sh0F
`define STS_T_WARM_HI      8'sh12
`define STS_T_HOT_LO       8'sh2F
`define STS_T_HOT_HI       8'sh37
`define STS_T_SIMULATED    8'sh0A

// ********************************************************
// Jumper codes
// ********************************************************
`define STS_JMP_NONE       2'h0
`define STS_JMP_ONBOARD    2'h1
`define STS_JMP_FIXED      2'h2

// ********************************************************
// Timing
// ********************************************************
`define STS_CLK_HZ         25000000
`define STS_FLASH_HZ       1
`define STS_FLASH_HALF     (`STS_CLK_HZ / (2 * `STS_FLASH_HZ))
`define STS_FLASH_W        24
`endif

/* hw/sts_sync2.v */
// Purpose: two-flop synchroniser for a vector of pins
// Assumes: inputs asynchronous to clk_i
// Notes:   first stage read only by the second
`timescale 1ns/1ps
module sts_sync2 #(
    parameter W = 1
) (
    input  wire         clk_i,  // Clock
    input  wire         rst_i,  // Sync reset
    input  wire [W-1:0] d_i,    // Async input
    input  wire [W-1:0] init_i, // Value in reset (constant)
    output reg  [W-1:0] q_o     // Synchronised
);
    reg [W-1:0] meta_reg;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= init_i;
            q_o      <= init_i;
        end
        else
        begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // sts_sync2

/* hw/sts_hyst.v */
// Purpose: one hysteresis comparator
// Assumes: signed temperature
// Notes:   above set at > hi, cleared at < lo, held between
`timescale 1ns/1ps
module sts_hyst #(
    parameter signed [7:0] LO   = 8'sh00,
    parameter signed [7:0] HI   = 8'sh03,
    parameter              INIT = 1'b0
) (
    input  wire              clk_i,  // Clock
    input  wire              rst_i,  // Sync reset
    input  wire signed [7:0] temp_i, // Temperature
    output reg               above_o // High side of the threshold
);
    always @(posedge clk_i)
    begin
        if (rst_i)
            above_o <= INIT;
        else if (temp_i > HI)
            above_o <= 1'b1;
        else if (temp_i < LO)
            above_o <= 1'b0;
    end
endmodule // sts_hyst

/* hw/sts_top.v */
// Purpose: temperature supervisor with ISA-style I/O port and Wishbone access
// Assumes: pins asynchronous, standby power equals clk running
// Notes:   Wishbone answers in one cycle; ISA reads answer combinationally
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "sts_defs.vh"
module sts_top (
    input  wire        clk_i,            // 25 MHz standby clock
    input  wire        rst_i,            // Sync reset, active high
    // Wishbone slave
    input  wire        wb_cyc_i,         // Cycle
    input  wire        wb_stb_i,         // Strobe
    input  wire        wb_we_i,          // Write enable
    input  wire [2:0]  wb_adr_i,         // Word index
    input  wire [3:0]  wb_sel_i,         // Byte lanes
    input  wire [31:0] wb_dat_i,         // Write data
    output reg  [31:0] wb_dat_o,         // Read data
    output reg         wb_ack_o,         // Acknowledge
    // ISA-style I/O pins
    input  wire [9:0]  isa_sa_i,         // Address lines
    input  wire        isa_aen_i,        // DMA address enable
    input  wire        isa_ior_n_i,      // Read strobe, low
    input  wire        isa_iow_n_i,      // Write strobe, low
    input  wire [7:0]  isa_sd_i,         // Data in
    output wire [7:0]  isa_sd_o,         // Data out
    output wire        isa_sd_oe_o,      // Data drive enable
    // Sensor and power status pins
    input  wire [1:0]  temp_source_jumper_i,       // Source jumper code
    input  wire signed [7:0] external_temp_i,      // Digitised external sensor
    input  wire        external_temp_sensor_short_i, // Sensor shorted
    input  wire        external_temp_sensor_open_i,  // Sensor open
    input  wire signed [7:0] onboard_temp_i,       // Digitised on-board sensor
    input  wire        battery_temp_sensor_short_i,  // Battery jumper fitted
    input  wire        mains_good_i,     // Mains judged good
    input  wire        rail5_ok_i,       // 5 V in tolerance
    input  wire        rail12_ok_i,      // 12 V in tolerance
    input  wire        rails_on_i,       // Main rails switched on
    input  wire        standby_on_i,     // Standby rail on
    input  wire        battery_present_i, // Battery present
    input  wire        ps_on_n_i,        // Power-on request, low
    input  wire        cpu_running_i,    // Main outputs already on
    // Outputs
    output reg         mode_indicator_green_o, // Mode LED green
    output reg         mode_indicator_red_o,   // Mode LED red
    output reg         mains_good_indicator_o, // Mains LED
    output reg         overtemp_indicator_o,   // Overtemp_indicator
    output reg         undertemp_indicator_o,  // Undertemp_indicator
    output reg         power_good_o,     // Power-good
    output reg         heater_on_o,      // Heater control
    output reg         fan_on_o,         // Fan control
    output reg         critical_alarm_o, // Critical alarm
    output reg         start_request_o,  // Start main outputs
    output reg         serial_mains_fail_o, // Serial mains failure
    output reg         serial_batt_low_o,   // Serial battery low
    output reg         batt_temp_ctrl_en_o  // Battery temperature control on
);
    // ********************************************************
    // Synchronisers
    // ********************************************************
    wire [28:0] pin_raw;
    wire [28:0] pin_s;
    assign pin_raw = {temp_source_jumper_i, external_temp_i, external_temp_sensor_short_i,
                      external_temp_sensor_open_i, onboard_temp_i, battery_temp_sensor_short_i,
                      mains_good_i, rail5_ok_i, rail12_ok_i, rails_on_i, standby_on_i,
                      battery_present_i, ps_on_n_i, cpu_running_i};

    // Sync inputs first
    // Request flushes high, so reset never looks like a start request
    sts_sync2 #(.W(29)) u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (pin_raw),
        .init_i (29'h0000002),
        .q_o    (pin_s)
    );

    wire [1:0]        jmp_s      = pin_s[28:27];
    wire signed [7:0] ext_s      = pin_s[26:19];
    wire              short_s    = pin_s[18];
    wire              open_s     = pin_s[17];
    wire signed [7:0] onb_s      = pin_s[16:9];
    wire              bshort_s   = pin_s[8];
    wire              mains_s    = pin_s[7];
    wire              r5_s       = pin_s[6];
    wire              r12_s      = pin_s[5];
    wire              rails_s    = pin_s[4];
    wire              stby_s     = pin_s[3];
    wire              batt_s     = pin_s[2];
    wire              ps_on_n_s  = pin_s[1];
    wire              running_s  = pin_s[0];

    // ********************************************************
    // Temperature source
    // ********************************************************
    reg signed [7:0] temp_sel;
    always @*
    begin
        case (jmp_s)
            `STS_JMP_ONBOARD: temp_sel = onb_s;
            `STS_JMP_FIXED:   temp_sel = `STS_T_SIMULATED;
            default:
            begin
                if (short_s)
                    temp_sel = 8'sh80;
                else if (open_s)
                    temp_sel = 8'sh7F;
                else
                    temp_sel = ext_s;
            end
        endcase
    end

    // ********************************************************
    // Hysteresis comparators
    // ********************************************************
    wire above_cold;
    wire above_warm;
    wire above_hot;
    // Bands are nested, so the three flags never disagree
    // Cold/cool band
    sts_hyst #(
        .LO   (`STS_T_COLD_LO),
        .HI   (`STS_T_COLD_HI),
        .INIT (1'b1)
    ) u_h0 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .temp_i  (temp_sel),
        .above_o (above_cold)
    );
    sts_hyst #(
        .LO   (`STS_T_WARM_LO),
        .HI   (`STS_T_WARM_HI),
        .INIT (1'b0)
    ) u_h1 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .temp_i  (temp_sel),
        .above_o (above_warm)
    );
    sts_hyst #(
        .LO   (`STS_T_HOT_LO),
        .HI   (`STS_T_HOT_HI),
        .INIT (1'b0)
    ) u_h2 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .temp_i  (temp_sel),
        .above_o (above_hot)
    );

    wire [1:0] range = !above_cold ? `STS_RANGE_COLD :
                       above_hot   ? `STS_RANGE_HOT  :
                       above_warm  ? `STS_RANGE_WARM : `STS_RANGE_COOL;

    // ********************************************************
    // Flash generator
    // ********************************************************
    reg [`STS_FLASH_W-1:0] flash_cnt_reg;
    reg                    flash_reg;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // Start lit so an extreme range shows at once
            flash_cnt_reg <= {`STS_FLASH_W{1'b0}};
            flash_reg     <= 1'b1;
        end
        else if (flash_cnt_reg == `STS_FLASH_HALF - 1)
        begin
            flash_cnt_reg <= {`STS_FLASH_W{1'b0}};
            flash_reg     <= ~flash_reg;
        end
        else
            flash_cnt_reg <= flash_cnt_reg + 1'b1;
    end

    // ********************************************************
    // Control register (Wishbone)
    // ********************************************************
    // Bit0 forces heater and fan off for maintenance
    reg  [7:0] ctrl_reg;
    wire       force_off = ctrl_reg[0];

    // ********************************************************
    // Output decode
    // ********************************************************
    wire start_allowed = (range == `STS_RANGE_COOL) || (range == `STS_RANGE_WARM);
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_indicator_green_o <= 1'b0;
            mode_indicator_red_o   <= 1'b0;
            mains_good_indicator_o <= 1'b0;
            overtemp_indicator_o   <= 1'b0;
            undertemp_indicator_o  <= 1'b0;
            power_good_o           <= 1'b0;
            heater_on_o            <= 1'b0;
            fan_on_o               <= 1'b0;
            critical_alarm_o       <= 1'b0;
            start_request_o        <= 1'b0;
            serial_mains_fail_o    <= 1'b0;
            serial_batt_low_o      <= 1'b0;
            batt_temp_ctrl_en_o    <= 1'b0;
        end
        else
        begin
            mode_indicator_green_o <= rails_s | stby_s;
            mode_indicator_red_o   <= ~rails_s & stby_s;
            mains_good_indicator_o <= mains_s;
            power_good_o           <= r5_s & r12_s;
            undertemp_indicator_o  <= (range == `STS_RANGE_COLD) & flash_reg;
            overtemp_indicator_o   <= (range == `STS_RANGE_HOT) & flash_reg;
            critical_alarm_o       <= (range == `STS_RANGE_HOT);
            heater_on_o            <= (range == `STS_RANGE_COLD) & ~force_off;
            fan_on_o               <= range[1] & ~force_off;
            serial_mains_fail_o    <= (range == `STS_RANGE_HOT) | ~mains_s;
            serial_batt_low_o      <= (range == `STS_RANGE_HOT);
            // Low request starts; gated; running holds
            start_request_o        <= ~ps_on_n_s & (start_allowed | (running_s & start_request_o));
            batt_temp_ctrl_en_o    <= ~bshort_s;
        end
    end

    // ********************************************************
    // Status byte
    // ********************************************************
    // Range code in low bits
    wire [7:0] status_byte = {4'h0, batt_s, mains_s, range};

    // ********************************************************
    // ISA-style port
    // ********************************************************
    // Decode with AEN low; 250h-257h only
    wire isa_hit = ~isa_aen_i &&
                   (isa_sa_i[9:`STS_IO_SPAN_BITS] == `STS_IO_BASE >> `STS_IO_SPAN_BITS);
    reg [7:0] isa_rd;
    always @*
    begin
        case (isa_sa_i[2:0])
            `STS_IDX_SIGNATURE: isa_rd = `STS_SIGNATURE_VAL;
            `STS_IDX_STATUS:    isa_rd = status_byte;
            default:            isa_rd = 8'h00;
        endcase
    end
    assign isa_sd_o    = isa_rd;
    assign isa_sd_oe_o = isa_hit & ~isa_ior_n_i;

    // ********************************************************
    // Wishbone slave
    // ********************************************************
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_reg <= `STS_CTRL_RESET;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `STS_IDX_SIGNATURE: wb_dat_o <= {24'h0, `STS_SIGNATURE_VAL};
                    `STS_IDX_STATUS:    wb_dat_o <= {24'h0, status_byte};
                    `STS_IDX_CONTROL:   wb_dat_o <= {24'h0, ctrl_reg};
                    default:            wb_dat_o <= 32'h0000_0000;
                endcase
            end
            if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `STS_IDX_CONTROL)
                ctrl_reg <= wb_dat_i[7:0];
        end
    end
endmodule // sts_top

/* testbench/sts_top_assertions.sv */
// Purpose: port checks for sts_top
// Assumes: pins reach outputs after 3 edges
// Notes:   bound to every sts_top
`timescale 1ns/1ps
module sts_top_assertions (
    input wire clk_i,                  // Clock
    input wire rst_i,                  // Reset
    input wire wb_cyc_i,               // Cycle
    input wire wb_stb_i,               // Strobe
    input wire wb_ack_o,               // Ack
    input wire mains_good_i,           // Mains
    input wire rail5_ok_i,             // 5 V
    input wire rail12_ok_i,            // 12 V
    input wire ps_on_n_i,              // Request
    input wire mains_good_indicator_o, // Mains LED
    input wire overtemp_indicator_o,   // Overtemp_indicator
    input wire power_good_o,           // Power good
    input wire heater_on_o,            // Heater
    input wire fan_on_o,               // Fan
    input wire critical_alarm_o,       // Alarm
    input wire start_request_o,        // Start
    input wire serial_mains_fail_o,    // Serial mains
    input wire serial_batt_low_o       // Serial battery
);
    reg  [2:0] rdy_reg;
    wire       rdy;
    // Past values from before reset are not trusted
    always @(posedge clk_i)
        if (rst_i)
            rdy_reg <= 3'h0;
        else if (!rdy)
            rdy_reg <= rdy_reg + 3'h1;
    assign rdy = (rdy_reg == 3'h4);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_WB_ACK: assert property (s_wb_req |=> s_ack_pulse)
        else $error("bus ack not a one-cycle answer");
    AST_MAINS_LED: assert property (rdy |-> mains_good_indicator_o == $past(mains_good_i, 3))
        else $error("mains indicator wrong");
    AST_PWR_GOOD: assert property (rdy |-> power_good_o == ($past(rail5_ok_i, 3) && $past(rail12_ok_i, 3)))
        else $error("power good wrong");
    AST_HOT_DECODE: assert property (critical_alarm_o |-> fan_on_o && !heater_on_o)
        else $error("hot decode wrong");
    AST_HEAT_FAN: assert property (heater_on_o |-> !fan_on_o && !critical_alarm_o)
        else $error("heater with fan");
    AST_SERIAL: assert property (critical_alarm_o |-> serial_mains_fail_o && serial_batt_low_o)
        else $error("serial alarm pair missing");
    AST_FLASH: assert property (overtemp_indicator_o |-> critical_alarm_o)
        else $error("hot flash outside range");
    AST_START_GATE: assert property (rdy && $rose(start_request_o) |-> !heater_on_o && !critical_alarm_o)
        else $error("start in extreme range");
    AST_KEEP_ON: assert property (rdy && $fell(start_request_o) |-> $past(ps_on_n_i, 3))
        else $error("start dropped while requested");
endmodule // sts_top_assertions

bind sts_top sts_top_assertions u_chk (.*);

/* testbench/sts_host_model.sv */
// Purpose: host side of the I/O bus and power request
// Assumes: one read per call, strobes held across edges
// Notes:   host never writes, its data lines toggle
`timescale 1ns/1ps
module sts_host_model (
    input  wire       clk_i,           // Clock
    input  wire [7:0] sd_i,            // Data from module
    input  wire       sd_oe_i,         // Module drives data
    output reg  [9:0] sa_o = 10'h3FF,  // Address
    output reg        aen_o = 1'b1,    // High ignores cycle
    output reg        ior_n_o = 1'b1,  // Read strobe
    output reg        iow_n_o = 1'b1,  // Write strobe, idle
    output reg  [7:0] sd_o = 8'h5A,    // Host data lines
    output reg        ps_on_n_o = 1'b1 // Power-on request
);
    // Undriven data never shows a stale value
    always @(posedge clk_i)
        sd_o <= ~sd_o;
    task automatic rd(input logic [9:0] a, input logic ae, output logic [7:0] d, output logic oe);
        @(posedge clk_i);
        sa_o <= a;
        aen_o <= ae;
        @(posedge clk_i);
        ior_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        d = sd_i;
        oe = sd_oe_i;
        ior_n_o <= 1'b1;
        aen_o <= 1'b1;
    endtask
    task automatic pwr(input logic v);
        @(posedge clk_i);
        ps_on_n_o <= v;
    endtask
endmodule // sts_host_model

/* testbench/tb_top.sv */
// Purpose: self-checking bench for sts_top
// Assumes: rows run in order, hysteresis carries over
// Notes:   flash period too long to watch toggling
`timescale 1ns/1ps
`include "sts_defs.vh"
module tb_top;
    typedef struct {logic [1:0] j; int t; logic sh; logic op; int ob; logic [1:0] rg;} sts_row_t;
    logic        clk_i = 1'b0, rst_i = 1'b1, cpu_running_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [2:0]  wb_adr_i = 3'h0;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [9:0]  isa_sa_i;
    logic        isa_aen_i, isa_ior_n_i, isa_iow_n_i, isa_sd_oe_o, ps_on_n_i, oe;
    logic [7:0]  isa_sd_i, isa_sd_o, d, external_temp_i = 8'h0A, onboard_temp_i = 8'h00;
    logic [1:0]  temp_source_jumper_i = 2'h0;
    logic        external_temp_sensor_short_i = 1'b0, external_temp_sensor_open_i = 1'b0;
    logic        battery_temp_sensor_short_i = 1'b0, battery_present_i = 1'b0, mains_good_i = 1'b0;
    logic        rail5_ok_i = 1'b0, rail12_ok_i = 1'b0, rails_on_i = 1'b0, standby_on_i = 1'b1;
    logic        mode_indicator_green_o, mode_indicator_red_o, mains_good_indicator_o, overtemp_indicator_o;
    logic        undertemp_indicator_o, power_good_o, heater_on_o, fan_on_o, critical_alarm_o;
    logic        start_request_o, serial_mains_fail_o, serial_batt_low_o, batt_temp_ctrl_en_o;
    int          err_total = 0, tests_run = 0, cyc = 0;
    sts_row_t    r;
    sts_row_t    rows [19] = '{'{0,3,0,0,0,1}, '{0,18,0,0,0,1}, '{0,19,0,0,0,2}, '{0,15,0,0,0,2},
        '{0,55,0,0,0,2}, '{0,56,0,0,0,3}, '{0,47,0,0,0,3}, '{0,46,0,0,0,2}, '{0,14,0,0,0,1},
        '{0,0,0,0,0,1}, '{0,-1,0,0,0,0}, '{0,3,0,0,0,0}, '{0,4,0,0,0,1}, '{0,-1,0,0,0,0},
        '{2,-1,0,0,0,1}, '{1,-1,0,0,30,2}, '{0,30,1,0,30,0}, '{0,30,0,1,30,3}, '{1,30,0,1,20,2}};
    sts_top u_dut (.*);
    sts_host_model u_host (.clk_i(clk_i), .sd_i(isa_sd_o), .sd_oe_i(isa_sd_oe_o), .sa_o(isa_sa_i),
        .aen_o(isa_aen_i), .ior_n_o(isa_ior_n_i), .iow_n_o(isa_iow_n_i), .sd_o(isa_sd_i), .ps_on_n_o(ps_on_n_i));
    initial
        forever #20 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
            test_done;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wbx(input logic we, input logic [2:0] a, input logic [31:0] dw, output logic [31:0] dr);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dw;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        dr = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic test_done;
        if (cyc >= 5000)
            err_total++;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        wt(2);
        cmp({heater_on_o, fan_on_o, critical_alarm_o, start_request_o, power_good_o}, 32'h0);
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            r = rows[i];
            temp_source_jumper_i <= r.j;
            external_temp_i <= r.t[7:0];
            external_temp_sensor_short_i <= r.sh;
            external_temp_sensor_open_i <= r.op;
            onboard_temp_i <= r.ob[7:0];
            mains_good_i <= i[0];
            rail5_ok_i <= i[0];
            battery_present_i <= i[1];
            rail12_ok_i <= i[2];
            rails_on_i <= i[2];
            battery_temp_sensor_short_i <= i[3];
            wt(6);
            cmp({heater_on_o, fan_on_o, critical_alarm_o}, {r.rg == 2'h0, r.rg[1], r.rg == 2'h3});
            cmp({power_good_o, mode_indicator_red_o, mains_good_indicator_o}, {i[0] & i[2], ~i[2], i[0]});
            cmp({mode_indicator_green_o, batt_temp_ctrl_en_o}, {1'b1, ~i[3]});
            cmp({undertemp_indicator_o, overtemp_indicator_o}, {r.rg == 2'h0, r.rg == 2'h3});
            cmp({serial_mains_fail_o, serial_batt_low_o}, {(r.rg == 2'h3) | ~i[0], r.rg == 2'h3});
            u_host.rd(10'h251, 1'b0, d, oe);
            cmp({oe, d}, {5'h10, i[1], i[0], r.rg});
        end
        u_host.rd(10'h250, 1'b0, d, oe);
        cmp({oe, d}, {1'b1, `STS_SIGNATURE_VAL});
        u_host.rd(10'h250, 1'b1, d, oe);
        cmp(oe, 32'h0);
        u_host.rd(10'h258, 1'b0, d, oe);
        cmp(oe, 32'h0);
        wbx(1'b0, 3'h0, 32'h0, q);
        cmp(q, {24'h0, `STS_SIGNATURE_VAL});
        wbx(1'b0, 3'h3, 32'h0, q);
        cmp(q, 32'h0);
        wbx(1'b1, 3'h5, 32'h1, q);
        wbx(1'b0, 3'h5, 32'h0, q);
        cmp(q, 32'h1);
        cmp({heater_on_o, fan_on_o}, 32'h0);
        wbx(1'b1, 3'h5, 32'h0, q);
        // Range gates start but never withdraws it once cpu_running_i is high
        temp_source_jumper_i <= 2'h0;
        external_temp_sensor_open_i <= 1'b0;
        external_temp_i <= 8'h3C;
        u_host.pwr(1'b0);
        wt(8);
        cmp(start_request_o, 32'h0);
        external_temp_i <= 8'h0A;
        wt(8);
        cmp(start_request_o, 32'h1);
        cpu_running_i <= 1'b1;
        external_temp_i <= 8'hFB;
        wt(8);
        cmp({start_request_o, heater_on_o}, 32'h3);
        u_host.pwr(1'b1);
        wt(8);
        cmp(start_request_o, 32'h0);
        // Converter off leaves the mode indicator dark
        standby_on_i <= 1'b0;
        rails_on_i <= 1'b0;
        wt(6);
        cmp({mode_indicator_green_o, mode_indicator_red_o}, 32'h0);
        // Mid-run reset clears outputs, then the range is found again
        rst_i <= 1'b1;
        wt(2);
        cmp({heater_on_o, fan_on_o, critical_alarm_o, start_request_o, power_good_o, wb_ack_o}, 32'h0);
        rst_i <= 1'b0;
        standby_on_i <= 1'b1;
        wt(8);
        cmp({heater_on_o, mode_indicator_green_o, mode_indicator_red_o}, 32'h7);
        test_done;
    end
endmodule // tb_top
